// ===== design/sesc_pkg.sv
// Operation
// - temperature status query returns 8-bit word, hex.
// - status preset clears both enable registers.
// - error query pops buffer, -0 when empty.
// - syntax errors use codes -100 to -120.
// - execution errors use codes -200, -204, -213.
// - parameter errors use codes -220 to -231.
// - buffer overflow records error -350.
// - query errors use codes -400, -410, -420.
// - keypad lock set 1/0, query reports state.
// - version query always returns 1995.0.
// - date set yyyy,mm,dd; answered dd.mm.yy.
// - time set hh,mm,ss; answered hh:mm:ss.
// - any command error answers NAK, not ACK.
package sesc_pkg;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	typedef enum logic [3:0] {
		SESC_CMD_TEMP_STAT = 4'h0,
		SESC_CMD_PRESET = 4'h1,
		SESC_CMD_ERROR = 4'h2,
		SESC_CMD_KEY_LOCK = 4'h3,
		SESC_CMD_VERSION = 4'h4,
		SESC_CMD_DATE = 4'h5,
		SESC_CMD_TIME = 4'h6,
		SESC_CMD_OPER_EN = 4'h7,
		SESC_CMD_QUES_EN = 4'h8
	} sesc_cmd_t;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SESC_ST_IDLE = 2'b00,
		SESC_ST_EXEC = 2'b01,
		SESC_ST_REPLY = 2'b11
	} sesc_state_t;

	// ----------------------------------------
	// Error code magnitudes (reported as negative numbers)
	// ----------------------------------------
	localparam logic [9:0] SESC_ERR_NONE = 10'h000;
	localparam logic [9:0] SESC_ERR_COMMAND = 10'h064;
	localparam logic [9:0] SESC_ERR_INV_CHAR = 10'h065;
	localparam logic [9:0] SESC_ERR_GET_NOT_ALLOWED = 10'h069;
	localparam logic [9:0] SESC_ERR_MISSING_PARAM = 10'h06D;
	localparam logic [9:0] SESC_ERR_HEADER = 10'h06E;
	localparam logic [9:0] SESC_ERR_NUMERIC = 10'h078;
	localparam logic [9:0] SESC_ERR_EXECUTION = 10'h0C8;
	localparam logic [9:0] SESC_ERR_ILLEGAL_STATE = 10'h0CC;
	localparam logic [9:0] SESC_ERR_INIT_IGNORED = 10'h0D5;
	localparam logic [9:0] SESC_ERR_PARAMETER = 10'h0DC;
	localparam logic [9:0] SESC_ERR_SETTING_CONFLICT = 10'h0DD;
	localparam logic [9:0] SESC_ERR_OUT_OF_RANGE = 10'h0DE;
	localparam logic [9:0] SESC_ERR_ILLEGAL_VALUE = 10'h0E0;
	localparam logic [9:0] SESC_ERR_QUESTIONABLE = 10'h0E7;
	localparam logic [9:0] SESC_ERR_OVERFLOW = 10'h15E;
	localparam logic [9:0] SESC_ERR_QUERY = 10'h190;
	localparam logic [9:0] SESC_ERR_QUERY_INTERRUPTED = 10'h19A;
	localparam logic [9:0] SESC_ERR_QUERY_UNTERMINATED = 10'h1A4;

	// ----------------------------------------
	// Sizes, limits and fixed answers
	// ----------------------------------------
	localparam int SESC_ERRQ_DEPTH = 8;
	localparam logic [3:0] SESC_ERRQ_FULL = 4'h8;
	localparam logic [15:0] SESC_ENABLE_MAX = 16'h7FFF;
	localparam logic [15:0] SESC_VERSION_INT = 16'h07CB;
	localparam logic [15:0] SESC_VERSION_FRAC = 16'h0000;
	localparam logic [7:0] SESC_MONTH_MAX = 8'h0C;
	localparam logic [7:0] SESC_DAY_MAX = 8'h1F;
	localparam logic [7:0] SESC_HOUR_MAX = 8'h17;
	localparam logic [7:0] SESC_MINSEC_MAX = 8'h3B;
	localparam logic [15:0] SESC_CENTURY = 16'h0064;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] SESC_RST_YEAR = 16'h07D0;
	localparam logic [7:0] SESC_RST_MONTH = 8'h01;
	localparam logic [7:0] SESC_RST_DAY = 8'h01;

endpackage

// ===== design/sesc_top.sv
module sesc_top
	import sesc_pkg::*;
(
	// Clock and reset
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	// Command request
	input wire logic I_CMD_VALID,
	input wire logic [3:0] I_CMD_CODE,
	input wire logic I_CMD_QUERY,
	input wire logic I_CMD_HAS_PARAM,
	input wire logic [31:0] I_CMD_PARAM,
	output logic O_CMD_READY,
	// Reply
	output logic O_RSP_VALID,
	output logic O_RSP_ACK,
	output logic O_RSP_NAK,
	output logic [31:0] O_RSP_DATA,
	// Error reports from the text parser
	input wire logic I_ERR_VALID,
	input wire logic [9:0] I_ERR_CODE,
	// Temperature measurement faults, bits 0 to 6
	input wire logic [6:0] I_TEMP_FAULT,
	// Settings driven into the instrument
	output logic O_KEY_LOCK,
	output logic [15:0] O_OPER_ENABLE,
	output logic [15:0] O_QUES_ENABLE
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
		input logic [7:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	sesc_state_t state_ff, nxt_state;
	logic [3:0] cmd_code_ff;
	logic cmd_query_ff, cmd_has_param_ff;
	logic [31:0] cmd_param_ff;
	logic ready_ff, rsp_valid_ff, rsp_ack_ff, rsp_nak_ff;
	logic [31:0] rsp_data_ff;
	logic [7:0] temp_status_ff;
	logic key_lock_ff;
	logic [15:0] oper_en_ff, ques_en_ff;
	logic [15:0] year_ff;
	logic [7:0] month_ff, day_ff, hour_ff, min_ff, sec_ff;
	logic [9:0] errq_ff [SESC_ERRQ_DEPTH];
	logic [2:0] errq_rd_ff;
	logic [3:0] errq_cnt_ff;

	logic exec;
	logic [9:0] exec_err;
	logic [31:0] exec_data;
	logic exec_pop;
	logic do_preset, do_lock, do_date, do_time, do_oper, do_ques;
	logic [9:0] nxt_errq [SESC_ERRQ_DEPTH];
	logic [2:0] nxt_errq_rd;
	logic [3:0] nxt_errq_cnt;
	logic [9:0] errq_head;
	logic [15:0] year_short;

	assign exec = (state_ff == SESC_ST_EXEC);
	assign errq_head = (errq_cnt_ff == 4'h0) ? SESC_ERR_NONE : errq_ff[errq_rd_ff];
	assign year_short = year_ff % SESC_CENTURY;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		case (state_ff)
			SESC_ST_IDLE: nxt_state = I_CMD_VALID ? SESC_ST_EXEC : SESC_ST_IDLE;
			SESC_ST_EXEC: nxt_state = SESC_ST_REPLY;
			SESC_ST_REPLY: nxt_state = SESC_ST_IDLE;
			default: nxt_state = SESC_ST_IDLE;
		endcase
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			state_ff <= SESC_ST_IDLE;
			ready_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ready_ff <= (nxt_state == SESC_ST_IDLE);
		end
	end

	// The request is latched so the host may change its lines after the handshake.
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			cmd_code_ff <= 4'h0;
			cmd_query_ff <= 1'b0;
			cmd_has_param_ff <= 1'b0;
			cmd_param_ff <= 32'h0000_0000;
		end else if (state_ff == SESC_ST_IDLE && I_CMD_VALID) begin
			cmd_code_ff <= I_CMD_CODE;
			cmd_query_ff <= I_CMD_QUERY;
			cmd_has_param_ff <= I_CMD_HAS_PARAM;
			cmd_param_ff <= I_CMD_PARAM;
		end
	end

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	// A parameter sent to a query-only command is ignored without an error.
	always_comb begin
		exec_err = SESC_ERR_NONE;
		exec_data = 32'h0000_0000;
		exec_pop = 1'b0;
		do_preset = 1'b0;
		do_lock = 1'b0;
		do_date = 1'b0;
		do_time = 1'b0;
		do_oper = 1'b0;
		do_ques = 1'b0;
		case (cmd_code_ff)
			SESC_CMD_TEMP_STAT: begin
				if (cmd_query_ff) begin
					exec_data = {24'h00_0000, temp_status_ff};
				end else begin
					exec_err = SESC_ERR_COMMAND;
				end
			end
			SESC_CMD_PRESET: begin
				if (cmd_query_ff) begin
					exec_err = SESC_ERR_COMMAND;
				end else begin
					do_preset = 1'b1;
				end
			end
			SESC_CMD_ERROR: begin
				if (cmd_query_ff) begin
					exec_pop = 1'b1;
					exec_data = {22'h00_0000, errq_head};
				end else begin
					exec_err = SESC_ERR_COMMAND;
				end
			end
			SESC_CMD_KEY_LOCK: begin
				if (cmd_query_ff) begin
					exec_data = {31'h0000_0000, key_lock_ff};
				end else if (!cmd_has_param_ff) begin
					exec_err = SESC_ERR_MISSING_PARAM;
				end else if (cmd_param_ff[31:1] != 31'h0000_0000) begin
					exec_err = SESC_ERR_PARAMETER;
				end else begin
					do_lock = 1'b1;
				end
			end
			SESC_CMD_VERSION: begin
				if (cmd_query_ff) begin
					exec_data = {SESC_VERSION_INT, SESC_VERSION_FRAC};
				end else begin
					exec_err = SESC_ERR_COMMAND;
				end
			end
			SESC_CMD_DATE: begin
				if (cmd_query_ff) begin
					exec_data = {8'h00, day_ff, month_ff, year_short[7:0]};
				end else if (!cmd_has_param_ff) begin
					exec_err = SESC_ERR_MISSING_PARAM;
				end else if (!in_range(cmd_param_ff[15:8], 8'h01, SESC_MONTH_MAX) ||
					!in_range(cmd_param_ff[7:0], 8'h01, SESC_DAY_MAX)) begin
					exec_err = SESC_ERR_OUT_OF_RANGE;
				end else begin
					do_date = 1'b1;
				end
			end
			SESC_CMD_TIME: begin
				if (cmd_query_ff) begin
					exec_data = {8'h00, hour_ff, min_ff, sec_ff};
				end else if (!cmd_has_param_ff) begin
					exec_err = SESC_ERR_MISSING_PARAM;
				end else if (!in_range(cmd_param_ff[23:16], 8'h00, SESC_HOUR_MAX) ||
					!in_range(cmd_param_ff[15:8], 8'h00, SESC_MINSEC_MAX) ||
					!in_range(cmd_param_ff[7:0], 8'h00, SESC_MINSEC_MAX)) begin
					exec_err = SESC_ERR_OUT_OF_RANGE;
				end else begin
					do_time = 1'b1;
				end
			end
			SESC_CMD_OPER_EN, SESC_CMD_QUES_EN: begin
				if (cmd_query_ff) begin
					exec_data = {16'h0000,
						(cmd_code_ff == SESC_CMD_OPER_EN) ? oper_en_ff : ques_en_ff};
				end else if (!cmd_has_param_ff) begin
					exec_err = SESC_ERR_MISSING_PARAM;
				end else if (cmd_param_ff > {16'h0000, SESC_ENABLE_MAX}) begin
					exec_err = SESC_ERR_OUT_OF_RANGE;
				end else begin
					do_oper = (cmd_code_ff == SESC_CMD_OPER_EN);
					do_ques = (cmd_code_ff == SESC_CMD_QUES_EN);
				end
			end
			default: exec_err = SESC_ERR_COMMAND;
		endcase
	end

	// ----------------------------------------
	// Reply
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			rsp_valid_ff <= 1'b0;
			rsp_ack_ff <= 1'b0;
			rsp_nak_ff <= 1'b0;
			rsp_data_ff <= 32'h0000_0000;
		end else begin
			rsp_valid_ff <= exec;
			rsp_ack_ff <= exec && (exec_err == SESC_ERR_NONE);
			rsp_nak_ff <= exec && (exec_err != SESC_ERR_NONE);
			rsp_data_ff <= exec ? exec_data : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Status, lock and enable registers
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			temp_status_ff <= 8'h00;
		end else begin
			temp_status_ff <= {1'b0, I_TEMP_FAULT};
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			key_lock_ff <= 1'b0;
		end else if (exec && do_lock) begin
			key_lock_ff <= cmd_param_ff[0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			oper_en_ff <= 16'h0000;
			ques_en_ff <= 16'h0000;
		end else if (exec) begin
			if (do_preset) begin
				oper_en_ff <= 16'h0000;
				ques_en_ff <= 16'h0000;
			end
			if (do_oper) begin
				oper_en_ff <= cmd_param_ff[15:0];
			end
			if (do_ques) begin
				ques_en_ff <= cmd_param_ff[15:0];
			end
		end
	end

	// ----------------------------------------
	// Date and time
	// ----------------------------------------
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			year_ff <= SESC_RST_YEAR;
			month_ff <= SESC_RST_MONTH;
			day_ff <= SESC_RST_DAY;
		end else if (exec && do_date) begin
			year_ff <= cmd_param_ff[31:16];
			month_ff <= cmd_param_ff[15:8];
			day_ff <= cmd_param_ff[7:0];
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			hour_ff <= 8'h00;
			min_ff <= 8'h00;
			sec_ff <= 8'h00;
		end else if (exec && do_time) begin
			hour_ff <= cmd_param_ff[23:16];
			min_ff <= cmd_param_ff[15:8];
			sec_ff <= cmd_param_ff[7:0];
		end
	end

	// ----------------------------------------
	// Error queue
	// ----------------------------------------
	// Up to two errors enter per cycle: the command's own first, then the parser's.
	// On a full queue the newest slot is overwritten with the overflow code.
	always_comb begin
		logic [3:0] cnt;
		logic [2:0] rd;
		logic [9:0] push [2];
		logic [1:0] npush;
		cnt = errq_cnt_ff;
		rd = errq_rd_ff;
		npush = 2'd0;
		push[0] = SESC_ERR_NONE;
		push[1] = SESC_ERR_NONE;
		nxt_errq = errq_ff;
		if (exec && exec_pop && cnt != 4'h0) begin
			rd = rd + 3'd1;
			cnt = cnt - 4'h1;
		end
		if (exec && exec_err != SESC_ERR_NONE) begin
			push[0] = exec_err;
			npush = 2'd1;
		end
		if (I_ERR_VALID && I_ERR_CODE != SESC_ERR_NONE) begin
			push[npush[0]] = I_ERR_CODE;
			npush = npush + 2'd1;
		end
		for (int i = 0; i < 2; i++) begin
			if (2'(i) < npush) begin
				if (cnt < SESC_ERRQ_FULL) begin
					nxt_errq[rd + cnt[2:0]] = push[i];
					cnt = cnt + 4'h1;
				end else begin
					nxt_errq[rd + 3'd7] = SESC_ERR_OVERFLOW;
				end
			end
		end
		nxt_errq_rd = rd;
		nxt_errq_cnt = cnt;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (!I_NRST) begin
			errq_rd_ff <= 3'd0;
			errq_cnt_ff <= 4'h0;
			for (int i = 0; i < SESC_ERRQ_DEPTH; i++) begin
				errq_ff[i] <= SESC_ERR_NONE;
			end
		end else begin
			errq_rd_ff <= nxt_errq_rd;
			errq_cnt_ff <= nxt_errq_cnt;
			errq_ff <= nxt_errq;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign O_CMD_READY = ready_ff;
	assign O_RSP_VALID = rsp_valid_ff;
	assign O_RSP_ACK = rsp_ack_ff;
	assign O_RSP_NAK = rsp_nak_ff;
	assign O_RSP_DATA = rsp_data_ff;
	assign O_KEY_LOCK = key_lock_ff;
	assign O_OPER_ENABLE = oper_en_ff;
	assign O_QUES_ENABLE = ques_en_ff;

endmodule

// ===== sim/sesc_host_model.sv
module sesc_host_model
	import sesc_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Command side
	output logic o_valid,
	output logic [3:0] o_code,
	output logic o_query,
	output logic o_has_param,
	output logic [31:0] o_param,
	input wire logic i_ready,
	// Reply side
	input wire logic i_rsp_valid,
	input wire logic i_ack,
	input wire logic i_nak,
	input wire logic [31:0] i_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial {o_valid, o_code, o_query, o_has_param, o_param} = {1'b0, 4'hF, 2'b00, 32'h5A5A_A5A5};

	// Holds a command until the taking edge, then waits a bounded time for the reply.
	task automatic send(input logic [3:0] c, input logic q, input logic hp, input logic [31:0] p,
		input int gap, output logic [1:0] an, output logic [31:0] d, output bit ok);
		ok = 0;
		repeat (gap + 1) @(posedge i_clk);
		{o_valid, o_code, o_query, o_has_param, o_param} <= {1'b1, c, q, hp, p};
		@(negedge i_clk);
		for (int i = 0; i < 16 && !i_ready; i++) @(negedge i_clk);
		@(posedge i_clk);
		// Released fields show the inverse so nothing stale looks like a command.
		{o_valid, o_code, o_param} <= {1'b0, ~c, ~p};
		for (int i = 0; i < 8 && !ok; i++) begin
			@(negedge i_clk);
			ok = i_rsp_valid;
		end
		an = {i_ack, i_nak};
		d = i_data;
	endtask
endmodule

// ===== sim/sesc_top_checker.sv
module sesc_top_checker
	import sesc_pkg::*;
(
	// Watched ports
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	input wire logic I_CMD_VALID,
	input wire logic [3:0] I_CMD_CODE,
	input wire logic I_CMD_QUERY,
	input wire logic I_CMD_HAS_PARAM,
	input wire logic [31:0] I_CMD_PARAM,
	input wire logic O_CMD_READY,
	input wire logic O_RSP_VALID,
	input wire logic O_RSP_ACK,
	input wire logic O_RSP_NAK,
	input wire logic [31:0] O_RSP_DATA,
	input wire logic O_KEY_LOCK,
	input wire logic [15:0] O_OPER_ENABLE,
	input wire logic [15:0] O_QUES_ENABLE
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	assign take = I_CMD_VALID && O_CMD_READY;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);

	rsp_delay_a: assert property (
		take |-> !O_RSP_VALID ##1 !O_RSP_VALID ##1 O_RSP_VALID)
		else $error("reply not two cycles after command");
	ready_gap_a: assert property (take |=> !O_CMD_READY [*2] ##1 O_CMD_READY)
		else $error("ready gap wrong");
	rsp_pulse_a: assert property (O_RSP_VALID |=> !O_RSP_VALID)
		else $error("reply longer than one cycle");
	ack_one_a: assert property (O_RSP_VALID |-> O_RSP_ACK != O_RSP_NAK)
		else $error("ack and nak not exclusive");
	quiet_out_a: assert property (
		!O_RSP_VALID |-> !O_RSP_ACK && !O_RSP_NAK && O_RSP_DATA == 32'h0000_0000)
		else $error("reply lines busy outside pulse");
	temp_word_a: assert property (
		$past(take, 2) && $past(I_CMD_CODE, 2) == SESC_CMD_TEMP_STAT |-> O_RSP_DATA[31:7] == 0)
		else $error("temperature word too wide");
	version_reply_a: assert property (
		$past(take, 2) && $past(I_CMD_CODE, 2) == SESC_CMD_VERSION && $past(I_CMD_QUERY, 2)
		|-> O_RSP_ACK && O_RSP_DATA == 32'h07CB_0000)
		else $error("version reply wrong");
	preset_clear_a: assert property (
		take && I_CMD_CODE == SESC_CMD_PRESET && !I_CMD_QUERY && !I_CMD_HAS_PARAM
		|-> ##2 O_OPER_ENABLE == 0 && O_QUES_ENABLE == 0)
		else $error("preset left enables set");
	lock_set_a: assert property (
		take && I_CMD_CODE == SESC_CMD_KEY_LOCK && !I_CMD_QUERY && I_CMD_HAS_PARAM
		&& I_CMD_PARAM[31:1] == 0 |-> ##2 O_KEY_LOCK == $past(I_CMD_PARAM[0], 2))
		else $error("keypad lock not set");
endmodule

bind sesc_top sesc_top_checker u_chk (.I_SYS_CLK, .I_NRST, .I_CMD_VALID, .I_CMD_CODE,
	.I_CMD_QUERY, .I_CMD_HAS_PARAM, .I_CMD_PARAM, .O_CMD_READY, .O_RSP_VALID, .O_RSP_ACK,
	.O_RSP_NAK, .O_RSP_DATA, .O_KEY_LOCK, .O_OPER_ENABLE, .O_QUES_ENABLE);

// ===== sim/tb_sesc_top.sv
module tb_sesc_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sesc_pkg::*;
	localparam logic [1:0] R_ACK = 2'h2;
	localparam logic [1:0] R_NAK = 2'h1;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic err_valid = 1'b0;
	logic [9:0] err_code = 10'h000;
	logic [6:0] temp_fault = 7'h00;
	logic valid, query, has_param, ready, rsp_valid, ack, nak, key_lock;
	logic [3:0] code;
	logic [31:0] param, data;
	logic [15:0] oper_en, ques_en;
	int miscompares = 0;
	int check_count = 0;
	logic [9:0] codes [17] = '{10'h064, 10'h065, 10'h069, 10'h06D, 10'h06E, 10'h078, 10'h0C8,
		10'h0CC, 10'h0D5, 10'h0DC, 10'h0DD, 10'h0DE, 10'h0E0, 10'h0E7, 10'h190, 10'h19A, 10'h1A4};

	always #2.5 clk = ~clk;

	sesc_top u_dut (.I_SYS_CLK(clk), .I_NRST(nrst), .I_CMD_VALID(valid), .I_CMD_CODE(code),
		.I_CMD_QUERY(query), .I_CMD_HAS_PARAM(has_param), .I_CMD_PARAM(param),
		.O_CMD_READY(ready), .O_RSP_VALID(rsp_valid), .O_RSP_ACK(ack), .O_RSP_NAK(nak),
		.O_RSP_DATA(data), .I_ERR_VALID(err_valid), .I_ERR_CODE(err_code),
		.I_TEMP_FAULT(temp_fault), .O_KEY_LOCK(key_lock), .O_OPER_ENABLE(oper_en),
		.O_QUES_ENABLE(ques_en));
	sesc_host_model u_host (.i_clk(clk), .o_valid(valid), .o_code(code), .o_query(query),
		.o_has_param(has_param), .o_param(param), .i_ready(ready), .i_rsp_valid(rsp_valid),
		.i_ack(ack), .i_nak(nak), .i_data(data));

	// ----
	// Checking
	// ----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmd(input logic [3:0] c, input logic q, input logic hp, input logic [31:0] p,
		input logic [1:0] an_exp, input logic [31:0] d_exp);
		logic [1:0] an;
		logic [31:0] d;
		bit ok;
		u_host.send(c, q, hp, p, check_count % 3, an, d, ok);
		if (!ok) begin
			miscompares++;
			complete_run();
		end
		check({30'h0, an}, {30'h0, an_exp});
		check(d, d_exp);
	endtask
	task automatic pop(input logic [9:0] e);
		cmd(SESC_CMD_ERROR, 1'b1, 1'b0, 32'h0000_0000, R_ACK, {22'h0, e});
	endtask
	task automatic push(input int first, input int n);
		for (int k = first; k < first + n; k++) begin
			@(posedge clk);
			err_valid <= 1'b1;
			err_code <= codes[k];
		end
		@(posedge clk);
		err_valid <= 1'b0;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_errors();
		pop(10'h000);
		for (int b = 0; b < 17; b += 8) begin
			push(b, (b < 16) ? 8 : 1);
			for (int k = b; k < b + 8 && k < 17; k++) pop(codes[k]);
		end
		push(0, 9);
		for (int k = 0; k < 8; k++) pop((k < 7) ? codes[k] : 10'h15E);
		pop(10'h000);
	endtask
	task automatic t_status();
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			temp_fault <= i ? 7'h2A : 7'h55;
			cmd(SESC_CMD_TEMP_STAT, 1'b1, 1'b0, 32'h0, R_ACK, i ? 32'h2A : 32'h55);
		end
		cmd(SESC_CMD_VERSION, 1'b1, 1'b1, 32'hFFFF_FFFF, R_ACK, 32'h07CB_0000);
		for (int v = 1; v >= 0; v--) begin
			cmd(SESC_CMD_KEY_LOCK, 1'b0, 1'b1, 32'(v), R_ACK, 32'h0);
			check({31'h0, key_lock}, 32'(v));
			cmd(SESC_CMD_KEY_LOCK, 1'b1, 1'b0, 32'h0, R_ACK, 32'(v));
		end
		cmd(SESC_CMD_KEY_LOCK, 1'b0, 1'b1, 32'h0000_0002, R_NAK, 32'h0);
	endtask
	task automatic t_clock();
		cmd(SESC_CMD_DATE, 1'b1, 1'b0, 32'h0, R_ACK, 32'h0001_0100);
		cmd(SESC_CMD_TIME, 1'b1, 1'b0, 32'h0, R_ACK, 32'h0);
		cmd(SESC_CMD_DATE, 1'b0, 1'b1, 32'h07E8_0C1F, R_ACK, 32'h0);
		cmd(SESC_CMD_DATE, 1'b1, 1'b0, 32'h0, R_ACK, 32'h001F_0C18);
		cmd(SESC_CMD_DATE, 1'b0, 1'b1, 32'h07E8_0D01, R_NAK, 32'h0);
		cmd(SESC_CMD_TIME, 1'b0, 1'b1, 32'h0017_3B3A, R_ACK, 32'h0);
		cmd(SESC_CMD_TIME, 1'b1, 1'b0, 32'h0, R_ACK, 32'h0017_3B3A);
		cmd(SESC_CMD_TIME, 1'b0, 1'b0, 32'h0, R_NAK, 32'h0);
	endtask
	task automatic t_preset();
		cmd(SESC_CMD_OPER_EN, 1'b0, 1'b1, 32'h0000_7FFF, R_ACK, 32'h0);
		cmd(SESC_CMD_QUES_EN, 1'b0, 1'b1, 32'h0000_1234, R_ACK, 32'h0);
		check({oper_en, ques_en}, 32'h7FFF_1234);
		cmd(SESC_CMD_PRESET, 1'b0, 1'b0, 32'h0, R_ACK, 32'h0);
		check({oper_en, ques_en}, 32'h0);
		cmd(SESC_CMD_QUES_EN, 1'b1, 1'b0, 32'h0, R_ACK, 32'h0);
		cmd(SESC_CMD_OPER_EN, 1'b0, 1'b1, 32'h0000_8000, R_NAK, 32'h0);
		cmd(SESC_CMD_PRESET, 1'b1, 1'b0, 32'h0, R_NAK, 32'h0);
		cmd(4'hF, 1'b1, 1'b0, 32'h0, R_NAK, 32'h0);
		pop(10'h0DC);
		pop(10'h0DE);
		pop(10'h06D);
		pop(10'h0DE);
		pop(10'h064);
		pop(10'h064);
		pop(10'h000);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		check({ready, key_lock, 14'h0, oper_en}, 32'h8000_0000);
		check({16'h0, ques_en}, 32'h0);
		t_errors();
		t_status();
		t_clock();
		t_preset();
		complete_run();
	end
endmodule
